// file: include/dcc_pkg.sv
// Purpose: Shared constants and state layout of the display config bank
// Assumes: 32-bit AXI4-Lite data, 16-bit byte addresses
// Notes: All reset values are zero
package dcc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] DCC_GEN_OFS = 16'h8304;
   localparam logic [15:0] DCC_TIM_OFS = 16'h8308;
   localparam logic [15:0] DCC_IRQ_STAT_OFS = 16'h8380;
   localparam logic [15:0] DCC_IRQ_MASK_OFS = 16'h8384;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DCC_FLOAD_BIT = 0;
   localparam int DCC_CURSOR_BIT = 1;
   localparam int DCC_VDIV_BIT = 2;
   localparam int DCC_PAN_BIT = 3;
   localparam int DCC_CMP_BIT = 4;
   localparam int DCC_DEC_BIT = 5;
   localparam int DCC_MUL_LSB = 6;
   localparam int DCC_START_LSB = 8;
   localparam int DCC_END_LSB = 12;
   localparam int DCC_VIDEO_BIT = 28;
   localparam int DCC_PDIV_BIT = 30;
   localparam int DCC_DDIV_BIT = 31;
   localparam int DCC_TIM_RW_W = 20;
   localparam int DCC_IRQ_W = 2;
   localparam int DCC_EVT_VERT = 0;
   localparam int DCC_EVT_URGENT = 1;

   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] DCC_MUL_LOW = 2'h0;
   localparam logic [1:0] DCC_MUL_HALF = 2'h1;
   localparam logic [1:0] DCC_MUL_ONE = 2'h2;
   localparam logic [1:0] DCC_MUL_TWO = 2'h3;
   localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
   localparam logic [31:0] DCC_GEN_RST = 32'h0000_0000;
   localparam logic [19:0] DCC_TIM_RST = 20'h0_0000;

   typedef struct packed {
      logic [31:0] gen;
      logic [19:0] tim;
      logic [1:0] stat;
      logic [1:0] mask;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [15:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic dck_s1;
      logic dck_s2;
      logic dck_s3;
      logic mul_ph;
      logic dot_ph;
      logic pix_ph;
      logic dot_en;
      logic pix_en;
      logic vclk;
      logic vclk_ph;
      logic urgent;
      logic [3:0] align;
      logic irq;
   } dcc_state_type;

   localparam dcc_state_type DCC_STATE_RST = '0;

endpackage : dcc_pkg

// file: rtl/dcc_config_bank.sv
// Purpose: Display controller general/timing configuration bank
// Assumes: FIFO depth, scan status and pan strobes come from aclk logic
// Notes: Dot clock pin is sampled, so aclk must exceed 4x its rate
`timescale 1ns/1ns

module dcc_config_bank
#(
   parameter int DEPTH_W = 7
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Dot clock pin and derived enables
   input wire logic dot_clock_in,
   output logic dot_clk_en,
   output logic pix_clk_en,
   // Video port
   output logic video_port_clock_out,
   output logic motion_video_port_on,
   // Display FIFO and memory controller
   input wire logic [DEPTH_W-1:0] fifo_level,
   output logic fifo_load_on,
   output logic fifo_urgent_fill_req,
   // Feature enables
   output logic decompressor_on,
   output logic compressor_on,
   output logic hw_cursor_on,
   // Scan status
   input wire logic vert_active,
   input wire logic vert_irq_evt,
   // Panning
   input wire logic split_cross,
   input wire logic pan_load,
   input wire logic [3:0] pan_align_in,
   output logic [3:0] pixel_align,
   // Interrupt
   output logic irq
);
   import dcc_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   if (DEPTH_W < 6)
   begin : g_depth_chk
      $error("DEPTH_W too small for a level of 60 entries");
   end

   function automatic logic [DEPTH_W-1:0] level_of(input logic [3:0] field);
      level_of = DEPTH_W'({field, 2'b00});
   endfunction : level_of

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      end
      merge = res;
   endfunction : merge

   dcc_state_type st_r;
   dcc_state_type st_nxt;
   logic [31:0] wr_val;
   logic [1:0] evt;
   logic mul_pulse;
   logic rise;
   logic fall;

   always_comb
   begin
      st_nxt = st_r;
      wr_val = 32'h0000_0000;
      evt = '0;
      mul_pulse = 1'b0;
      rise = st_r.dck_s2 && !st_r.dck_s3;
      fall = !st_r.dck_s2 && st_r.dck_s3;

      // ----------------------------------------------------------------
      // Write channel
      // ----------------------------------------------------------------
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready)
         st_nxt.bvalid = 1'b0;
      if (st_r.aw_got && st_r.w_got)
      begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = DCC_RESP_OKAY;
         unique case (st_r.awaddr[15:2])
            DCC_GEN_OFS[15:2]:
               st_nxt.gen = merge(st_r.gen, st_r.wdata, st_r.wstrb);
            DCC_TIM_OFS[15:2]:
            begin
               // Status bits 31:30 are read-only
               wr_val = merge({12'h000, st_r.tim}, st_r.wdata, st_r.wstrb);
               st_nxt.tim = wr_val[DCC_TIM_RW_W-1:0];
            end
            DCC_IRQ_STAT_OFS[15:2]:
            begin
               wr_val = merge(32'h0000_0000, st_r.wdata, st_r.wstrb);
               st_nxt.stat = st_r.stat & ~wr_val[DCC_IRQ_W-1:0];
            end
            DCC_IRQ_MASK_OFS[15:2]:
            begin
               wr_val = merge({30'h0000_0000, st_r.mask}, st_r.wdata, st_r.wstrb);
               st_nxt.mask = wr_val[DCC_IRQ_W-1:0];
            end
            default:
               st_nxt.bresp = DCC_RESP_SLVERR;
         endcase
      end
      st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

      // ----------------------------------------------------------------
      // Read channel
      // ----------------------------------------------------------------
      if (st_r.rvalid && s_axi_rready)
         st_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && st_r.arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = DCC_RESP_OKAY;
         unique case (s_axi_araddr[15:2])
            DCC_GEN_OFS[15:2]:
               st_nxt.rdata = st_r.gen;
            DCC_TIM_OFS[15:2]:
               st_nxt.rdata = {st_r.stat[DCC_EVT_VERT], !vert_active,
                               10'h000, st_r.tim};
            DCC_IRQ_STAT_OFS[15:2]:
               st_nxt.rdata = {30'h0000_0000, st_r.stat};
            DCC_IRQ_MASK_OFS[15:2]:
               st_nxt.rdata = {30'h0000_0000, st_r.mask};
            default:
            begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = DCC_RESP_SLVERR;
            end
         endcase
      end
      st_nxt.arready = !st_nxt.rvalid;

      // ----------------------------------------------------------------
      // Dot and pixel clock enables
      // ----------------------------------------------------------------
      // The second and third stages feed the edge detector
      st_nxt.dck_s1 = dot_clock_in;
      st_nxt.dck_s2 = st_r.dck_s1;
      st_nxt.dck_s3 = st_r.dck_s2;
      unique case (st_r.gen[DCC_MUL_LSB +: 2])
         DCC_MUL_LOW:
            mul_pulse = 1'b0;
         DCC_MUL_HALF:
         begin
            if (rise)
               st_nxt.mul_ph = !st_r.mul_ph;
            mul_pulse = rise && st_r.mul_ph;
         end
         DCC_MUL_ONE:
            mul_pulse = rise;
         DCC_MUL_TWO:
            mul_pulse = rise || fall;
      endcase
      // Divide stages sit after the multiplier
      st_nxt.dot_en = 1'b0;
      st_nxt.pix_en = 1'b0;
      if (mul_pulse)
      begin
         st_nxt.dot_ph = !st_r.dot_ph;
         st_nxt.dot_en = !st_r.gen[DCC_DDIV_BIT] || st_r.dot_ph;
      end
      if (st_nxt.dot_en)
      begin
         st_nxt.pix_ph = !st_r.pix_ph;
         st_nxt.pix_en = !st_r.gen[DCC_PDIV_BIT] || st_r.pix_ph;
      end

      // ----------------------------------------------------------------
      // Video port clock
      // ----------------------------------------------------------------
      // Held low while the port is off, so no stray edge reaches it
      if (!st_r.gen[DCC_VIDEO_BIT])
      begin
         st_nxt.vclk = 1'b0;
         st_nxt.vclk_ph = 1'b0;
      end
      else if (!st_r.gen[DCC_VDIV_BIT])
         st_nxt.vclk = !st_r.vclk;
      else
      begin
         st_nxt.vclk_ph = !st_r.vclk_ph;
         if (st_r.vclk_ph)
            st_nxt.vclk = !st_r.vclk;
      end

      // ----------------------------------------------------------------
      // Urgent fill request
      // ----------------------------------------------------------------
      if (!st_r.gen[DCC_FLOAD_BIT])
         st_nxt.urgent = 1'b0;
      else if (st_r.urgent && fifo_level >= level_of(st_r.gen[DCC_END_LSB +: 4]))
         st_nxt.urgent = 1'b0;
      else if (!st_r.urgent && fifo_level <= level_of(st_r.gen[DCC_START_LSB +: 4]))
      begin
         st_nxt.urgent = 1'b1;
         evt[DCC_EVT_URGENT] = 1'b1;
      end

      // ----------------------------------------------------------------
      // Pixel alignment
      // ----------------------------------------------------------------
      if (split_cross && st_r.gen[DCC_PAN_BIT])
         st_nxt.align = 4'h0;
      else if (pan_load && !split_cross)
         st_nxt.align = pan_align_in;
      // Crossing with compat off leaves the alignment as is

      // ----------------------------------------------------------------
      // Interrupt status, set beats clear
      // ----------------------------------------------------------------
      evt[DCC_EVT_VERT] = vert_irq_evt;
      st_nxt.stat = st_nxt.stat | evt;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= DCC_STATE_RST;
         st_r.gen <= DCC_GEN_RST;
         st_r.tim <= DCC_TIM_RST;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign dot_clk_en = st_r.dot_en;
   assign pix_clk_en = st_r.pix_en;
   assign video_port_clock_out = st_r.vclk;
   assign motion_video_port_on = st_r.gen[DCC_VIDEO_BIT];
   assign fifo_load_on = st_r.gen[DCC_FLOAD_BIT];
   assign fifo_urgent_fill_req = st_r.urgent;
   assign decompressor_on = st_r.gen[DCC_DEC_BIT];
   assign compressor_on = st_r.gen[DCC_CMP_BIT];
   assign hw_cursor_on = st_r.gen[DCC_CURSOR_BIT];
   assign pixel_align = st_r.align;
   assign irq = st_r.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   fill_off_quiet_a: assert property (!fifo_load_on |=> !fifo_urgent_fill_req)
      else $error("urgent request while FIFO load disabled");
   urgent_start_a: assert property (fifo_load_on && !fifo_urgent_fill_req
      && fifo_level <= level_of(st_r.gen[DCC_START_LSB +: 4])
      && fifo_level < level_of(st_r.gen[DCC_END_LSB +: 4])
      && $stable(st_r.gen) |=> fifo_urgent_fill_req)
      else $error("urgent request not raised at start level");
   urgent_end_a: assert property (fifo_urgent_fill_req && fifo_load_on
      && fifo_level >= level_of(st_r.gen[DCC_END_LSB +: 4]) |=> !fifo_urgent_fill_req)
      else $error("urgent request not dropped at end level");
   urgent_stat_a: assert property ($rose(fifo_urgent_fill_req)
      |-> st_r.stat[DCC_EVT_URGENT])
      else $error("urgent status bit not set");
   dot_low_a: assert property (st_r.gen[DCC_MUL_LSB +: 2] == DCC_MUL_LOW
      && $past(st_r.gen[DCC_MUL_LSB +: 2]) == DCC_MUL_LOW |=> !dot_clk_en)
      else $error("dot enable while multiplier forced low");
   dot_one_a: assert property (st_r.gen[DCC_MUL_LSB +: 2] == DCC_MUL_ONE
      && !st_r.gen[DCC_DDIV_BIT] && st_r.dck_s2 && !st_r.dck_s3 |=> dot_clk_en)
      else $error("dot enable missing on input rise");
   pix_sub_a: assert property (pix_clk_en |-> dot_clk_en)
      else $error("pixel enable without dot enable");
   vclk_off_a: assert property (!st_r.gen[DCC_VIDEO_BIT] |=> !video_port_clock_out)
      else $error("video clock runs while port disabled");
   vclk_half_a: assert property (st_r.gen[DCC_VIDEO_BIT] && !st_r.gen[DCC_VDIV_BIT]
      && $past(st_r.gen[DCC_VIDEO_BIT]) |=> video_port_clock_out != $past(video_port_clock_out))
      else $error("video clock not at half rate");
   vclk_quarter_a: assert property (st_r.gen[DCC_VIDEO_BIT] && st_r.gen[DCC_VDIV_BIT]
      ##1 st_r.gen[DCC_VIDEO_BIT] && st_r.gen[DCC_VDIV_BIT]
      |=> video_port_clock_out != $past(video_port_clock_out, 2))
      else $error("video clock not at quarter rate");
   pan_force_a: assert property (split_cross && st_r.gen[DCC_PAN_BIT] |=> pixel_align == 4'h0)
      else $error("alignment not forced at split crossing");
   pan_keep_a: assert property (split_cross && !st_r.gen[DCC_PAN_BIT] |=> $stable(pixel_align))
      else $error("alignment changed at split crossing");
   vertical_irq_pending_set_a: assert property (vert_irq_evt |=> st_r.stat[DCC_EVT_VERT])
      else $error("vertical pending lost");
   vna_read_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == DCC_TIM_OFS
      |=> s_axi_rvalid && s_axi_rdata[30] == !$past(vert_active))
      else $error("vertical inactive flag misread");
   irq_level_a: assert property (irq == |(st_r.stat & st_r.mask))
      else $error("interrupt output mismatch");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response not on time");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response not on time");

   urgent_cycle_c: cover property (fifo_urgent_fill_req ##[1:200] !fifo_urgent_fill_req);
   double_dot_c: cover property (st_r.gen[DCC_MUL_LSB +: 2] == DCC_MUL_TWO && dot_clk_en);
   vclk_quarter_c: cover property (st_r.gen[DCC_VIDEO_BIT] && st_r.gen[DCC_VDIV_BIT]
      && $rose(video_port_clock_out));
   write_resp_c: cover property (s_axi_bvalid && s_axi_bready);
   half_dot_c: cover property (st_r.gen[DCC_MUL_LSB +: 2] == DCC_MUL_HALF && dot_clk_en);

endmodule : dcc_config_bank

// file: sim/dcc_mem_model.sv
// Purpose: Memory controller and display FIFO level model
// Assumes: One 64-bit entry moves per fill beat, display drains slowly
// Notes: Slow mode fills only every fourth cycle
`timescale 1ns/1ns

module dcc_mem_model
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Display block side
   input wire logic fifo_load_on,
   input wire logic fifo_urgent_fill_req,
   // Bench controls
   input wire logic preset,
   input wire logic [6:0] preset_level,
   input wire logic fill_slow,
   output logic [6:0] fifo_level
);
   logic [1:0] tick_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fifo_level <= 7'h00;
         tick_r <= 2'h0;
      end
      else if (preset)
         fifo_level <= preset_level;
      // Level frozen while loading is off
      else if (fifo_load_on)
      begin
         tick_r <= tick_r + 2'h1;
         // Fill only while asked, no kinder than needed
         if (fifo_urgent_fill_req && (!fill_slow || tick_r == 2'h0) && fifo_level != 7'h7f)
            fifo_level <= fifo_level + 7'h01;
         else if (!fifo_urgent_fill_req && tick_r == 2'h0 && fifo_level != 7'h00)
            fifo_level <= fifo_level - 7'h01;
      end
   end
endmodule : dcc_mem_model

// file: sim/dcc_testbench.sv
// Purpose: Self-checking bench of the display config bank
// Assumes: Dot pin period of 16 aclk cycles
// Notes: Clock counts allow one pulse of window slack
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t mismatch %0h %0h", $time, (a), (b)); end end

module testbench;
   import dcc_pkg::*;
   int failures = 0;
   int checked = 0;
   logic aclk = 0, aresetn = 0;
   logic [15:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0, strb = 4'hf;
   logic dck = 0, vact = 1, vevt = 0, scross = 0, pload = 0, preset = 0, slow = 0;
   logic [3:0] pin = 0;
   logic [6:0] plev = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [6:0] lvl, held;
   logic [3:0] palign;
   logic dot_en, pix_en, vclk, vid_on, load_on, ureq, dec_on, cmp_on, cur_on, irq;
   int dck_n = 0;

   always #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      dck_n <= dck_n + 1;
      if (dck_n % 8 == 7)
         dck <= ~dck;
   end

   dcc_config_bank DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .dot_clock_in(dck), .dot_clk_en(dot_en), .pix_clk_en(pix_en),
      .video_port_clock_out(vclk), .motion_video_port_on(vid_on), .fifo_level(lvl),
      .fifo_load_on(load_on), .fifo_urgent_fill_req(ureq), .decompressor_on(dec_on),
      .compressor_on(cmp_on), .hw_cursor_on(cur_on), .vert_active(vact),
      .vert_irq_evt(vevt), .split_cross(scross), .pan_load(pload),
      .pan_align_in(pin), .pixel_align(palign), .irq(irq));

   dcc_mem_model mem (.aclk(aclk), .aresetn(aresetn), .fifo_load_on(load_on),
      .fifo_urgent_fill_req(ureq), .preset(preset), .preset_level(plev),
      .fill_slow(slow), .fifo_level(lvl));

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= strb; awvalid <= 1; wvalid <= 1; bready <= 1;
      repeat (100)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) begin rsp = bresp; bready <= 0; return; end
      end
      failures++;
   endtask : wr

   task automatic rdr(input logic [15:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      repeat (100)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) begin rd = rdata; rsp = rresp; rready <= 0; return; end
      end
      failures++;
   endtask : rdr

   function automatic logic near(int a, int e);
      return (a >= e - 1) && (a <= e + 1);
   endfunction : near

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rdr(DCC_GEN_OFS);
      `CHK(rd, DCC_GEN_RST)
      `CHK(rsp, DCC_RESP_OKAY)
      rdr(DCC_TIM_OFS);
      `CHK(rd[19:0], DCC_TIM_RST)
      rdr(16'h8000);
      `CHK(rsp, DCC_RESP_SLVERR)
      wr(16'h8010, 32'hffff_ffff);
      `CHK(rsp, DCC_RESP_SLVERR)
   endtask : t_reset

   task automatic t_enables();
      wr(DCC_GEN_OFS, 32'h1000_0032);
      `CHK(rsp, DCC_RESP_OKAY)
      `CHK({dec_on, cmp_on, cur_on}, 3'h7)
      `CHK(vid_on, 1'b1)
      wr(DCC_GEN_OFS, 32'h0000_0000);
      `CHK({dec_on, cmp_on, cur_on, vid_on, load_on}, 5'h00)
      wr(DCC_TIM_OFS, 32'hffff_ffff);
      rdr(DCC_TIM_OFS);
      `CHK(rd, 32'h000f_ffff)
      strb = 4'h2;
      wr(DCC_TIM_OFS, 32'h0000_0000);
      strb = 4'hf;
      rdr(DCC_TIM_OFS);
      `CHK(rd, 32'h000f_00ff)
   endtask : t_enables

   task automatic t_timing();
      vact <= 1;
      rdr(DCC_TIM_OFS);
      `CHK(rd[31:30], 2'h0)
      vact <= 0;
      rdr(DCC_TIM_OFS);
      `CHK(rd[30], 1'b1)
      @(posedge aclk) vevt <= 1;
      @(posedge aclk) vevt <= 0;
      rdr(DCC_TIM_OFS);
      `CHK(rd[31], 1'b1)
      `CHK(irq, 1'b0)
      wr(DCC_IRQ_MASK_OFS, 32'h0000_0001);
      `CHK(irq, 1'b1)
      wr(DCC_IRQ_STAT_OFS, 32'h0000_0001);
      `CHK(irq, 1'b0)
      rdr(DCC_TIM_OFS);
      `CHK(rd[31], 1'b0)
      vact <= 1;
   endtask : t_timing

   task automatic t_urgent(input logic s);
      slow <= s;
      @(posedge aclk) begin preset <= 1; plev <= 7'h14; end
      @(posedge aclk) preset <= 0;
      wr(DCC_IRQ_MASK_OFS, 32'h0000_0002);
      // Start field two (level 8), end field four (level 16)
      wr(DCC_GEN_OFS, 32'h0000_4201);
      `CHK(load_on, 1'b1)
      repeat (300) @(posedge aclk) if (ureq === 1'b1) break;
      `CHK(lvl <= 7'h08, 1'b1)
      `CHK(ureq, 1'b1)
      repeat (300) @(posedge aclk) if (ureq === 1'b0) break;
      `CHK(lvl >= 7'h10, 1'b1)
      rdr(DCC_IRQ_STAT_OFS);
      `CHK(rd[1:0], 2'h2)
      `CHK(irq, 1'b1)
      // Outputs are idle here, so loading may stop
      wr(DCC_GEN_OFS, 32'h0000_0000);
      held = lvl;
      repeat (20) @(posedge aclk);
      `CHK(lvl, held)
      `CHK(ureq, 1'b0)
      wr(DCC_IRQ_STAT_OFS, 32'h0000_0002);
      `CHK(irq, 1'b0)
   endtask : t_urgent

   task automatic cnt(input logic [31:0] g, output int dn, output int pn, output int vn);
      logic pv;
      wr(DCC_GEN_OFS, g);
      repeat (20) @(posedge aclk);
      dn = 0; pn = 0; vn = 0; pv = vclk;
      repeat (160)
      begin
         @(posedge aclk);
         dn += (dot_en === 1'b1);
         pn += (pix_en === 1'b1);
         vn += (vclk !== pv);
         pv = vclk;
      end
   endtask : cnt

   task automatic t_dot();
      int dn, pn, vn;
      int ed[4] = '{0, 5, 10, 20};
      for (int m = 0; m < 4; m++)
      begin
         cnt(32'h1000_0000 | (m << DCC_MUL_LSB), dn, pn, vn);
         `CHK(near(dn, ed[m]), 1'b1)
         `CHK(near(pn, ed[m]), 1'b1)
         `CHK(near(vn, 160), 1'b1)
      end
      cnt(32'hd000_00c4, dn, pn, vn);
      `CHK(near(dn, 10), 1'b1)
      `CHK(near(pn, 5), 1'b1)
      `CHK(near(vn, 80), 1'b1)
      cnt(32'h0000_0004, dn, pn, vn);
      `CHK(vn, 0)
      `CHK(vclk, 1'b0)
   endtask : t_dot

   task automatic t_pan();
      @(posedge aclk) begin pload <= 1; pin <= 4'h5; end
      @(posedge aclk) pload <= 0;
      @(posedge aclk) scross <= 1;
      @(posedge aclk) scross <= 0;
      @(posedge aclk);
      `CHK(palign, 4'h5)
      wr(DCC_GEN_OFS, 32'h0000_0008);
      @(posedge aclk) scross <= 1;
      @(posedge aclk) scross <= 0;
      @(posedge aclk);
      `CHK(palign, 4'h0)
   endtask : t_pan

   task automatic stop_test();
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   initial
   begin
      #200000;
      failures++;
      stop_test();
   end

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_enables();
      t_timing();
      t_urgent(1'b0);
      t_urgent(1'b1);
      t_dot();
      t_pan();
      stop_test();
   end
endmodule : testbench
